// ===== rtl/lcbs_pkg.sv
// package: register map, field positions, reset values, codes and timing for link control
package lcbs_pkg;
  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] HC_CTRL_SET_OFS = 8'h00;
  localparam logic [7:0] HC_CTRL_CLR_OFS = 8'h04;
  localparam logic [7:0] FAIR_BUDGET_OFS = 8'h08;
  localparam logic [7:0] LINK_CTRL_SET_OFS = 8'h0c;
  localparam logic [7:0] LINK_CTRL_CLR_OFS = 8'h10;
  localparam logic [7:0] CONTEXT_CTRL_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;

  // ************************************************************
  // host_controller_control fields
  // ************************************************************
  localparam int HC_LPS_BIT = 0;
  localparam int HC_LINK_EN_BIT = 1;
  localparam int HC_NO_SWAP_BIT = 2;
  localparam int HC_SOFT_RST_BIT = 3;
  localparam logic [3:0] HC_CTRL_RESET = 4'h0;

  // ************************************************************
  // other fields and reset values
  // ************************************************************
  localparam int FAIR_WIDTH = 8;
  localparam logic [7:0] FAIR_BUDGET_RESET = 8'h00;
  localparam logic [31:0] LINK_CTRL_RESET = 32'h0000_0000;
  localparam int CTX_RUN_BIT = 0;
  localparam int ST_LCLK_RUN_BIT = 0;
  localparam int ST_SOFT_RST_BIT = 1;
  localparam int ST_STATE_LSB = 4;
  localparam int ST_USED_LSB = 8;

  // ************************************************************
  // transaction codes
  // ************************************************************
  localparam logic [3:0] TC_WR_QUAD = 4'h0;
  localparam logic [3:0] TC_WR_BLOCK = 4'h1;
  localparam logic [3:0] TC_RD_QUAD = 4'h4;
  localparam logic [3:0] TC_RD_BLOCK = 4'h5;
  localparam logic [3:0] TC_RD_QUAD_RSP = 4'h6;
  localparam logic [3:0] TC_RD_BLOCK_RSP = 4'h7;
  localparam logic [3:0] TC_LOCK_REQ = 4'h9;
  localparam logic [3:0] TC_STREAM = 4'ha;
  localparam logic [3:0] TC_LOCK_RSP = 4'hb;
  localparam logic [3:0] TC_PHY_PKT = 4'he;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int SYS_CLK_PERIOD_NS = 4;
  localparam int LCLK_TIMEOUT_NS = 1000;
  localparam int LCLK_TIMEOUT_CYC = LCLK_TIMEOUT_NS / SYS_CLK_PERIOD_NS;
  localparam int SOFT_RST_CYC = 4;

  typedef enum logic [3:0] {
    LCBS_PWR_OFF = 4'b0001,
    LCBS_PWR_ON = 4'b0010,
    LCBS_PWR_LINKED = 4'b0100,
    LCBS_PWR_RUN = 4'b1000
  } lcbs_pwr_t;
endpackage

// ===== rtl/lcbs_swap.sv
// byte order selection for one quadlet of packet data
`timescale 1ns/100ps
module lcbs_swap (
  input wire logic [31:0] quad_in,
  input wire logic [3:0] tcode,
  input wire logic is_header,
  input wire logic is_cycle_time,
  input wire logic no_swap,
  output logic [31:0] quad_out,
  output logic eligible
);
  import lcbs_pkg::*;
  logic do_swap;

  always_comb begin
    unique case (tcode)
      TC_WR_BLOCK, TC_RD_BLOCK_RSP, TC_LOCK_REQ, TC_STREAM, TC_LOCK_RSP: eligible = 1'b1;
      TC_WR_QUAD: eligible = 1'b1;
      TC_RD_QUAD_RSP: eligible = 1'b1;
      default: eligible = 1'b0;
    endcase
    // headers, the local cycle time and phy packets (tcode e) are never swapped
    if (is_header || is_cycle_time || tcode == TC_PHY_PKT) begin
      eligible = 1'b0;
    end
  end

  assign do_swap = eligible && !no_swap;

  // byte reversal only: bit order inside each byte stays msb first
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_byte
      assign quad_out[8*i +: 8] = do_swap ? quad_in[8*(3-i) +: 8] : quad_in[8*i +: 8];
    end
  endgenerate
endmodule

// ===== rtl/lcbs_top.sv
// link power sequencing, set/clear control registers, fairness limit and data byte swap
`timescale 1ns/100ps
module lcbs_top #(
  parameter int LINK_CTRL_WIDTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link clock from the phy
  input wire logic link_clk,
  // transmit quadlet stream from dma
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic [3:0] tx_tcode,
  input wire logic tx_is_header,
  input wire logic tx_is_cycle_time,
  output logic tx_out_valid,
  output logic [31:0] tx_out_data,
  // receive quadlet stream from the phy side
  input wire logic rx_valid,
  input wire logic [31:0] rx_data,
  input wire logic [3:0] rx_tcode,
  input wire logic rx_is_header,
  output logic rx_out_valid,
  output logic [31:0] rx_out_data,
  // priority arbitration
  input wire logic fair_interval_start,
  input wire logic arb_req,
  input wire logic [3:0] arb_tcode,
  output logic arb_grant,
  // enables to the rest of the controller
  output logic phy_access_enable,
  output logic phys_dma_enable,
  output logic cycle_start_enable,
  output logic full_func_enable,
  output logic [LINK_CTRL_WIDTH-1:0] link_ctrl
);
  import lcbs_pkg::*;

  // ************************************************************
  // control state
  // ************************************************************
  logic lps_reg;
  logic link_en_reg;
  logic no_swap_reg;
  logic [2:0] soft_cnt_reg;
  logic [FAIR_WIDTH-1:0] fair_budget_reg;
  logic [LINK_CTRL_WIDTH-1:0] link_ctrl_reg;
  logic ctx_run_reg;
  lcbs_pwr_t pwr_state_reg;
  lcbs_pwr_t pwr_state_next;
  logic soft_rst;
  logic soft_busy;
  logic [FAIR_WIDTH-1:0] pri_used_reg;

  // ************************************************************
  // apb decode
  // ************************************************************
  logic acc;
  logic wr;
  logic rd;
  logic hit;
  assign acc = clk_en && psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign hit = paddr == HC_CTRL_SET_OFS || paddr == HC_CTRL_CLR_OFS
            || paddr == FAIR_BUDGET_OFS || paddr == LINK_CTRL_SET_OFS
            || paddr == LINK_CTRL_CLR_OFS || paddr == CONTEXT_CTRL_OFS
            || paddr == STATUS_OFS;
  assign soft_rst = wr && paddr == HC_CTRL_SET_OFS && pwdata[HC_SOFT_RST_BIT];
  assign soft_busy = soft_cnt_reg != 3'h0;

  // one wait-free access phase: ready rises for the cycle after setup
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
    end
  end

  // ************************************************************
  // link clock sampling
  // ************************************************************
  logic [2:0] lclk_sync_reg;
  logic lclk_edge;
  logic [7:0] lclk_idle_reg;
  logic lclk_running_reg;
  localparam logic [7:0] LCLK_TIMEOUT = 8'(LCLK_TIMEOUT_CYC - 1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lclk_sync_reg <= 3'h0;
    end else if (clk_en) begin
      lclk_sync_reg <= {lclk_sync_reg[1:0], link_clk};
    end
  end
  assign lclk_edge = lclk_sync_reg[2] != lclk_sync_reg[1];

  // software polls this before touching phy side setup
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lclk_idle_reg <= 8'h00;
      lclk_running_reg <= 1'b0;
    end else if (clk_en) begin
      if (!lps_reg) begin
        lclk_idle_reg <= 8'h00;
        lclk_running_reg <= 1'b0;
      end else if (lclk_edge) begin
        lclk_idle_reg <= 8'h00;
        lclk_running_reg <= 1'b1;
      end else if (lclk_idle_reg == LCLK_TIMEOUT) begin
        lclk_running_reg <= 1'b0;
      end else begin
        lclk_idle_reg <= lclk_idle_reg + 8'h01;
      end
    end
  end

  // ************************************************************
  // host controller control (set / clear)
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_cnt_reg <= 3'h0;
    end else if (clk_en) begin
      if (soft_rst) begin
        soft_cnt_reg <= 3'(SOFT_RST_CYC);
      end else if (soft_busy) begin
        soft_cnt_reg <= soft_cnt_reg - 3'h1;
      end
    end
  end

  // power and link enable clear only by reset or soft reset; the clear address ignores them
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lps_reg <= HC_CTRL_RESET[HC_LPS_BIT];
      link_en_reg <= HC_CTRL_RESET[HC_LINK_EN_BIT];
      no_swap_reg <= HC_CTRL_RESET[HC_NO_SWAP_BIT];
    end else if (clk_en) begin
      if (soft_rst || soft_busy) begin
        lps_reg <= 1'b0;
        link_en_reg <= 1'b0;
        no_swap_reg <= HC_CTRL_RESET[HC_NO_SWAP_BIT];
      end else if (wr && paddr == HC_CTRL_SET_OFS) begin
        lps_reg <= lps_reg | pwdata[HC_LPS_BIT];
        link_en_reg <= link_en_reg | pwdata[HC_LINK_EN_BIT];
        no_swap_reg <= no_swap_reg | pwdata[HC_NO_SWAP_BIT];
      end else if (wr && paddr == HC_CTRL_CLR_OFS) begin
        no_swap_reg <= no_swap_reg & ~pwdata[HC_NO_SWAP_BIT];
      end
    end
  end

  // ************************************************************
  // link control, fairness budget, context run
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_ctrl_reg <= LINK_CTRL_RESET[LINK_CTRL_WIDTH-1:0];
    end else if (clk_en) begin
      if (soft_busy) begin
        link_ctrl_reg <= LINK_CTRL_RESET[LINK_CTRL_WIDTH-1:0];
      end else if (wr && paddr == LINK_CTRL_SET_OFS) begin
        link_ctrl_reg <= link_ctrl_reg | pwdata[LINK_CTRL_WIDTH-1:0];
      end else if (wr && paddr == LINK_CTRL_CLR_OFS) begin
        link_ctrl_reg <= link_ctrl_reg & ~pwdata[LINK_CTRL_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fair_budget_reg <= FAIR_BUDGET_RESET;
      ctx_run_reg <= 1'b0;
    end else if (clk_en) begin
      if (soft_busy) begin
        ctx_run_reg <= 1'b0;
      end else if (wr && paddr == CONTEXT_CTRL_OFS) begin
        ctx_run_reg <= pwdata[CTX_RUN_BIT];
      end
      if (wr && paddr == FAIR_BUDGET_OFS) begin
        fair_budget_reg <= pwdata[FAIR_WIDTH-1:0];
      end
    end
  end

  // ************************************************************
  // power sequence state
  // ************************************************************
  // out-of-order enables fall back to the lowest stage reached
  always_comb begin
    pwr_state_next = LCBS_PWR_OFF;
    if (lps_reg && link_en_reg && ctx_run_reg) begin
      pwr_state_next = LCBS_PWR_RUN;
    end else if (lps_reg && link_en_reg) begin
      pwr_state_next = LCBS_PWR_LINKED;
    end else if (lps_reg) begin
      pwr_state_next = LCBS_PWR_ON;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_state_reg <= LCBS_PWR_OFF;
      phy_access_enable <= 1'b0;
      phys_dma_enable <= 1'b0;
      cycle_start_enable <= 1'b0;
      full_func_enable <= 1'b0;
      link_ctrl <= LINK_CTRL_RESET[LINK_CTRL_WIDTH-1:0];
    end else if (clk_en) begin
      pwr_state_reg <= pwr_state_next;
      phy_access_enable <= lps_reg;
      phys_dma_enable <= lps_reg && link_en_reg;
      cycle_start_enable <= lps_reg && link_en_reg;
      full_func_enable <= lps_reg && link_en_reg && ctx_run_reg;
      link_ctrl <= link_ctrl_reg;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  logic [31:0] rd_mux;
  logic [31:0] hc_word;
  logic [31:0] lc_word;
  always_comb begin
    hc_word = 32'h0000_0000;
    hc_word[HC_LPS_BIT] = lps_reg;
    hc_word[HC_LINK_EN_BIT] = link_en_reg;
    hc_word[HC_NO_SWAP_BIT] = no_swap_reg;
    hc_word[HC_SOFT_RST_BIT] = soft_busy;
    lc_word = 32'h0000_0000;
    lc_word[LINK_CTRL_WIDTH-1:0] = link_ctrl_reg;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      HC_CTRL_SET_OFS, HC_CTRL_CLR_OFS: rd_mux = hc_word;
      FAIR_BUDGET_OFS: rd_mux[FAIR_WIDTH-1:0] = fair_budget_reg;
      LINK_CTRL_SET_OFS, LINK_CTRL_CLR_OFS: rd_mux = lc_word;
      CONTEXT_CTRL_OFS: rd_mux[CTX_RUN_BIT] = ctx_run_reg;
      STATUS_OFS: begin
        rd_mux[ST_LCLK_RUN_BIT] = lclk_running_reg;
        rd_mux[ST_SOFT_RST_BIT] = soft_busy;
        rd_mux[ST_STATE_LSB +: 4] = pwr_state_reg;
        rd_mux[ST_USED_LSB +: FAIR_WIDTH] = pri_used_reg;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= psel && !penable && !hit;
    end
  end

  // ************************************************************
  // data path byte order
  // ************************************************************
  logic [31:0] tx_swapped;
  logic [31:0] rx_swapped;
  logic tx_elig;
  logic rx_elig;

  lcbs_swap u_tx_swap (
    .quad_in(tx_data),
    .tcode(tx_tcode),
    .is_header(tx_is_header),
    .is_cycle_time(tx_is_cycle_time),
    .no_swap(no_swap_reg),
    .quad_out(tx_swapped),
    .eligible(tx_elig)
  );

  // the cycle time never arrives on receive, it is generated locally
  lcbs_swap u_rx_swap (
    .quad_in(rx_data),
    .tcode(rx_tcode),
    .is_header(rx_is_header),
    .is_cycle_time(1'b0),
    .no_swap(no_swap_reg),
    .quad_out(rx_swapped),
    .eligible(rx_elig)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_out_valid <= 1'b0;
      tx_out_data <= 32'h0000_0000;
      rx_out_valid <= 1'b0;
      rx_out_data <= 32'h0000_0000;
    end else if (clk_en) begin
      tx_out_valid <= tx_valid && lps_reg && link_en_reg;
      rx_out_valid <= rx_valid && lps_reg && link_en_reg;
      if (tx_valid) begin
        tx_out_data <= tx_swapped;
      end
      if (rx_valid) begin
        rx_out_data <= rx_swapped;
      end
    end
  end

  // ************************************************************
  // fairness limit
  // ************************************************************
  logic governed;
  logic [FAIR_WIDTH-1:0] pri_cap;
  always_comb begin
    unique case (arb_tcode)
      TC_WR_QUAD, TC_WR_BLOCK, TC_RD_QUAD, TC_RD_BLOCK, TC_LOCK_REQ, TC_STREAM:
        governed = 1'b1;
      default: governed = 1'b0;
    endcase
  end
  // zero budget behaves as one request per interval
  assign pri_cap = (fair_budget_reg == 8'h00) ? 8'h01 : fair_budget_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pri_used_reg <= 8'h00;
      arb_grant <= 1'b0;
    end else if (clk_en) begin
      arb_grant <= 1'b0;
      if (fair_interval_start) begin
        pri_used_reg <= 8'h00;
      end else if (arb_req && lps_reg && link_en_reg) begin
        if (!governed) begin
          arb_grant <= 1'b1;
        end else if (pri_used_reg < pri_cap) begin
          arb_grant <= 1'b1;
          pri_used_reg <= pri_used_reg + 8'h01;
        end
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_tx_take;
    clk_en && tx_valid;
  endsequence
  sequence s_soft;
    clk_en && soft_rst;
  endsequence

  a_header_msb_first: assert property (s_tx_take and tx_is_header |=>
    tx_out_data == $past(tx_data)) else $error("header quadlet reordered");
  a_little_endian_order: assert property (s_tx_take and tx_elig && !no_swap_reg |=>
    tx_out_data[7:0] == $past(tx_data[31:24]) && tx_out_data[31:24] == $past(tx_data[7:0]))
    else $error("little endian data not swapped");
  a_big_endian_order: assert property (s_tx_take and no_swap_reg |=>
    tx_out_data == $past(tx_data)) else $error("big endian data altered");
  a_cycle_time_kept: assert property (s_tx_take and tx_is_cycle_time |=>
    tx_out_data == $past(tx_data)) else $error("cycle time swapped");
  a_phy_pkt_kept: assert property (clk_en && rx_valid && rx_tcode == TC_PHY_PKT |=>
    rx_out_data == $past(rx_data)) else $error("phy packet swapped");
  a_rx_data_swap: assert property (clk_en && rx_valid && rx_elig && !no_swap_reg |=>
    rx_out_data == {$past(rx_data[7:0]), $past(rx_data[15:8]), $past(rx_data[23:16]),
    $past(rx_data[31:24])}) else $error("receive data not swapped");
  a_soft_reset_clears: assert property (s_soft |=> (!lps_reg && !link_en_reg) [*4])
    else $error("soft reset left power or link on");
  a_no_phy_comm: assert property (clk_en && !lps_reg |=> !phy_access_enable)
    else $error("phy access while power status off");
  a_link_gate: assert property (clk_en && !link_en_reg |=> !tx_out_valid && !rx_out_valid)
    else $error("packet moved with link disabled");
  a_fair_cap: assert property (arb_grant && governed |-> pri_used_reg <= pri_cap)
    else $error("fairness budget exceeded");
  a_set_bits: assert property (wr && paddr == LINK_CTRL_SET_OFS && !soft_busy |=>
    (link_ctrl_reg & $past(pwdata[LINK_CTRL_WIDTH-1:0])) == $past(pwdata[LINK_CTRL_WIDTH-1:0]))
    else $error("set write missed a bit");
  a_clear_bits: assert property (wr && paddr == LINK_CTRL_CLR_OFS && !soft_busy |=>
    (link_ctrl_reg & $past(pwdata[LINK_CTRL_WIDTH-1:0])) == '0)
    else $error("clear write missed a bit");
endmodule

// ===== testbench/lcbs_phy_model.sv
// phy stand-in that supplies the link clock while link power is on
`timescale 1ns/100ps
module lcbs_phy_model #(
  parameter int HALF_NS = 80
) (
  input wire logic link_power,
  output logic link_clk
);
  // ****************
  // link clock
  // ****************
  // stands still low while unpowered, so a stale edge never looks like life
  initial begin
    link_clk = 1'b0;
    #7.3;
    forever begin
      #(HALF_NS);
      link_clk = link_power ? ~link_clk : 1'b0;
    end
  end
endmodule

// ===== testbench/lcbs_top_tb_top.sv
// self-checking bench for link control, fairness and data byte swap
`timescale 1ns/100ps
module lcbs_top_tb_top;
  import lcbs_pkg::*;
  typedef struct packed {
    logic [3:0] tc;
    logic hdr;
    logic ct;
    logic tx_sw;
    logic rx_sw;
  } lcbs_row_t;
  logic sys_clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, link_ctrl, tx_data, tx_out_data, rx_data, rx_out_data;
  logic link_clk, tx_valid, tx_is_header, tx_is_cycle_time, tx_out_valid, rx_valid;
  logic rx_is_header, rx_out_valid, fair_interval_start, arb_req, arb_grant;
  logic [3:0] tx_tcode, rx_tcode, arb_tcode;
  logic phy_access_enable, phys_dma_enable, cycle_start_enable, full_func_enable;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // row = {tcode, header, cycle time, tx swapped, rx swapped}; cycle time flag is tx only
  lcbs_row_t rows [11] = '{8'h03, 8'h13, 8'h63, 8'h73, 8'h93, 8'ha3, 8'hb3, 8'h40,
    8'he0, 8'h18, 8'h15};

  lcbs_phy_model phy (.link_power(phy_access_enable), .link_clk(link_clk));
  lcbs_top dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_clk(link_clk), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_tcode(tx_tcode), .tx_is_header(tx_is_header), .tx_is_cycle_time(tx_is_cycle_time),
    .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_tcode(rx_tcode), .rx_is_header(rx_is_header),
    .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data),
    .fair_interval_start(fair_interval_start), .arb_req(arb_req), .arb_tcode(arb_tcode),
    .arb_grant(arb_grant), .phy_access_enable(phy_access_enable),
    .phys_dma_enable(phys_dma_enable), .cycle_start_enable(cycle_start_enable),
    .full_func_enable(full_func_enable), .link_ctrl(link_ctrl)
  );

  // ****************
  // tasks
  // ****************
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 1, pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic send(input lcbs_row_t r, input logic [31:0] d, input logic live);
    logic [31:0] s;
    s = {d[7:0], d[15:8], d[23:16], d[31:24]};
    @(posedge sys_clk);
    tx_valid <= 1'b1;
    rx_valid <= 1'b1;
    tx_data <= d;
    rx_data <= d;
    tx_tcode <= r.tc;
    rx_tcode <= r.tc;
    tx_is_header <= r.hdr;
    rx_is_header <= r.hdr;
    tx_is_cycle_time <= r.ct;
    @(posedge sys_clk);
    tx_valid <= 1'b0;
    rx_valid <= 1'b0;
    #1;
    chk("tx_out_data", r.tx_sw ? s : d, tx_out_data);
    chk("rx_out_data", r.rx_sw ? s : d, rx_out_data);
    chk("tx_out_valid", {31'h0, live}, {31'h0, tx_out_valid});
    chk("rx_out_valid", {31'h0, live}, {31'h0, rx_out_valid});
  endtask

  task automatic fair(input logic [3:0] tc, input int exp);
    int g;
    g = 0;
    @(posedge sys_clk);
    fair_interval_start <= 1'b1;
    @(posedge sys_clk);
    fair_interval_start <= 1'b0;
    arb_req <= 1'b1;
    arb_tcode <= tc;
    for (int k = 0; k < 10; k++) begin
      @(posedge sys_clk);
      if (arb_grant === 1'b1) begin
        g++;
      end
      if (k == 5) begin
        arb_req <= 1'b0;
      end
    end
    chk("arb_grants", 32'(exp), 32'(g));
  endtask

  // ****************
  // clock, timeout and sequence
  // ****************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // sized well above the sequence, which needs about 350 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, tx_valid, tx_data, tx_tcode, tx_is_header} = '0;
    {tx_is_cycle_time, rx_valid, rx_data, rx_tcode, rx_is_header} = '0;
    {fair_interval_start, arb_req, arb_tcode} = '0;
    clk_en = 1'b1;
    rst_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk("phy_access_enable", 0, phy_access_enable);
    chk("phys_dma_enable", 0, phys_dma_enable);
    apb(1'b0, HC_CTRL_SET_OFS, 0);
    chk("host_ctrl", 0, rd);
    apb(1'b1, HC_CTRL_SET_OFS, 32'h1 << HC_LPS_BIT);
    rd = 0;
    for (int n = 0; n < 40 && rd[ST_LCLK_RUN_BIT] !== 1'b1; n++) begin
      apb(1'b0, STATUS_OFS, 0);
    end
    chk("link_clk_running", 1, rd[ST_LCLK_RUN_BIT]);
    settle();
    chk("phy_access_enable", 1, phy_access_enable);
    chk("phys_dma_enable", 0, phys_dma_enable);
    apb(1'b1, HC_CTRL_SET_OFS, 32'h1 << HC_LINK_EN_BIT);
    settle();
    chk("cycle_start_enable", 1, cycle_start_enable);
    chk("full_func_enable", 0, full_func_enable);
    apb(1'b1, CONTEXT_CTRL_OFS, 32'h1 << CTX_RUN_BIT);
    settle();
    chk("full_func_enable", 1, full_func_enable);
    for (int i = 0; i < 11; i++) begin
      send(rows[i], 32'h1234_5678 + 32'h0101_0101 * 32'(i), 1'b1);
    end
    // clock enable low must freeze the data path even with a quadlet offered
    @(posedge sys_clk);
    clk_en <= 1'b0;
    tx_valid <= 1'b1;
    tx_data <= 32'hdead_beef;
    repeat (3) @(posedge sys_clk);
    tx_valid <= 1'b0;
    clk_en <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("tx_out_valid_frozen", 0, {31'h0, tx_out_valid});
    chk("tx_out_data_frozen", 32'h1c3e_6082, tx_out_data);
    apb(1'b1, LINK_CTRL_SET_OFS, 32'h8000_00a5);
    apb(1'b1, LINK_CTRL_CLR_OFS, 32'h0000_0081);
    apb(1'b0, LINK_CTRL_SET_OFS, 0);
    chk("link_ctrl_set_port", 32'h8000_0024, rd);
    apb(1'b0, LINK_CTRL_CLR_OFS, 0);
    chk("link_ctrl_clear_port", 32'h8000_0024, rd);
    apb(1'b1, LINK_CTRL_SET_OFS, 32'h0000_0100);
    settle();
    chk("link_ctrl", 32'h8000_0124, link_ctrl);
    apb(1'b1, 8'h1c, 32'hffff_ffff);
    chk("pslverr", 1, err);
    apb(1'b0, 8'h1c, 0);
    chk("unmapped_read", 0, rd);
    apb(1'b1, FAIR_BUDGET_OFS, 32'h2);
    apb(1'b0, FAIR_BUDGET_OFS, 0);
    chk("fairness_budget", 32'h2, rd);
    for (int t = 0; t < 16; t++) begin
      fair(4'(t), (t inside {0, 1, 4, 5, 9, 10}) ? 2 : 6);
    end
    apb(1'b1, FAIR_BUDGET_OFS, 32'h0);
    fair(TC_LOCK_REQ, 1);
    apb(1'b1, HC_CTRL_SET_OFS, 32'h1 << HC_SOFT_RST_BIT);
    apb(1'b0, STATUS_OFS, 0);
    chk("soft_reset_busy", 1, rd[ST_SOFT_RST_BIT]);
    repeat (SOFT_RST_CYC + 2) @(posedge sys_clk);
    #1;
    chk("phy_access_enable", 0, phy_access_enable);
    chk("cycle_start_enable", 0, cycle_start_enable);
    chk("link_ctrl", 0, link_ctrl);
    apb(1'b1, HC_CTRL_SET_OFS, 32'h1 << HC_LPS_BIT | 32'h1 << HC_NO_SWAP_BIT);
    send(8'h10, 32'h8899_aabb, 1'b0);
    // the clear address drops swap disable but leaves power status alone
    apb(1'b1, HC_CTRL_CLR_OFS, 32'h7);
    apb(1'b0, HC_CTRL_CLR_OFS, 0);
    chk("host_ctrl_clear", 32'h1 << HC_LPS_BIT, rd);
    fair(TC_WR_QUAD, 0);
    final_report();
  end
endmodule
